// *** rtl/e3_test_port.v ***
// E3 test port: clock selection, framer, pattern generator, HDB3 codec and receive checker.
`timescale 1ns/1ns
`include "e3_defines.vh"
// How it works
// - Frames are 1536 bits at 22.375 kHz.
// - Twelve overhead bits, four optional parity bits.
// - Nominal 34.368 Mbit/s, receiver tolerates 125 ppm.
// - Clock internal, external or recovered; detect lamp.
// - Transmitter off stops driving; E3 transmits.
// - Frame insertion adds overhead, else pattern only.
// - PRBS orders 9 to 31, plus off.
// - Zeros, ones and four alternating ratios.
// - Normal or inverted pattern on both sides.
// - Standard preset selects inverted PRBS 23.
// - User patterns of 1..32 or 1..2048 bits.
// - Second transmitter may copy first transmitter.
// - Receiver may copy transmitter or first receiver.
// - Receiver off halts all reception processing.
// - Receive framing off skips frame status.
// - Checker uses same patterns as generator.
// - Report LOS, AIS, no frame, distant, no sync.
// - Count alignment word mismatches against 1111010000.
// - Count each mismatching payload pattern bit while in sync.
// - Flag pattern slips, count line code errors.

////////////////////////////////////////////////////////////////////////////////
// Bit FIFO between the pattern generator and the framer.
module e3_bit_fifo #(parameter WIDTH = 1, parameter DEPTH = `FIFO_DEPTH) (
  input wire core_clk,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = $clog2(DEPTH);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW:0] wr_reg;
  reg [AW:0] rd_reg;
  wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire empty = (wr_reg == rd_reg);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_reg[rd_reg[AW-1:0]];
  // Extra pointer bit tells full from empty without a separate count.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
  // Storage has no reset; a word is only read after it was written.
  always @(posedge core_clk) begin
    if (in_valid && !full) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule // e3_bit_fifo

////////////////////////////////////////////////////////////////////////////////
module e3_test_port (
  input wire core_clk,
  input wire arst_n,
  input wire [`CFG_W-1:0] tx_cfg,
  input wire [`CFG_W-1:0] p1_tx_cfg,
  input wire [`CFG_W-1:0] rx_cfg,
  input wire [`CFG_W-1:0] p1_rx_cfg,
  input wire port_is_first,
  input wire tx_follow,
  input wire [1:0] rx_follow,
  input wire std_preset,
  input wire [1:0] tx_clk_src,
  input wire ext_clk,
  input wire user_wr_en,
  input wire [10:0] user_wr_addr,
  input wire user_wr_data,
  input wire [11:0] user_len,
  output reg line_pos,
  output reg line_neg,
  output reg line_oe,
  input wire rx_clk,
  input wire rx_pos,
  input wire rx_neg,
  output wire tx_clk_detected,
  output reg alarm_los,
  output reg alarm_ais,
  output reg alarm_no_frame,
  output reg alarm_distant,
  output reg alarm_no_sync,
  output reg [15:0] faw_err_cnt,
  output reg [15:0] pat_err_cnt,
  output reg [15:0] code_err_cnt,
  output reg [15:0] slip_cnt
);
  // Feedback taps of a maximal length LFSR for each order.
  function [31:0] prbs_mask;
    input [4:0] ord;
    begin
      case (ord)
        5'd9: prbs_mask = 32'h00000110;
        5'd10: prbs_mask = 32'h00000240;
        5'd11: prbs_mask = 32'h00000500;
        5'd12: prbs_mask = 32'h00000829;
        5'd13: prbs_mask = 32'h0000100d;
        5'd14: prbs_mask = 32'h00002015;
        5'd15: prbs_mask = 32'h00006000;
        5'd16: prbs_mask = 32'h0000d008;
        5'd17: prbs_mask = 32'h00012000;
        5'd18: prbs_mask = 32'h00020400;
        5'd19: prbs_mask = 32'h00040023;
        5'd20: prbs_mask = 32'h00090000;
        5'd21: prbs_mask = 32'h00140000;
        5'd22: prbs_mask = 32'h00300000;
        5'd23: prbs_mask = 32'h00420000;
        5'd24: prbs_mask = 32'h00e10000;
        5'd25: prbs_mask = 32'h01200000;
        5'd26: prbs_mask = 32'h02000023;
        5'd27: prbs_mask = 32'h04000013;
        5'd28: prbs_mask = 32'h09000000;
        5'd29: prbs_mask = 32'h14000000;
        5'd30: prbs_mask = 32'h20000029;
        5'd31: prbs_mask = 32'h48000000;
        default: prbs_mask = 32'h00000110;
      endcase
    end
  endfunction

  // Repeat length of a word pattern; a zero user length acts as one bit.
  function [11:0] pat_len;
    input [3:0] pat;
    input [11:0] ulen;
    begin
      case (pat)
        `PAT_ALT11: pat_len = 12'h002;
        `PAT_ALT13: pat_len = 12'h004;
        `PAT_ALT17: pat_len = 12'h008;
        `PAT_ALT324: pat_len = 12'h01b;
        `PAT_USER_SHORT: pat_len = (ulen == 12'h000) ? 12'h001 :
                                   (ulen > 12'h020) ? 12'h020 : ulen;
        `PAT_USER_LONG: pat_len = (ulen == 12'h000) ? 12'h001 :
                                  (ulen > 12'h800) ? 12'h800 : ulen;
        default: pat_len = 12'h001;
      endcase
    end
  endfunction

  // Bit of a word pattern at a position within its repeat.
  // Fixed, alternating and user words
  function word_bit;
    input [3:0] pat;
    input [11:0] idx;
    input ubit;
    begin
      case (pat)
        `PAT_ONES: word_bit = 1'b1;
        `PAT_ALT11: word_bit = (idx[0] == 1'b0);
        `PAT_ALT13: word_bit = (idx[1:0] == 2'h0);
        `PAT_ALT17: word_bit = (idx[2:0] == 3'h0);
        `PAT_ALT324: word_bit = (idx < 12'h003);
        `PAT_USER_SHORT: word_bit = ubit;
        `PAT_USER_LONG: word_bit = ubit;
        default: word_bit = 1'b0;
      endcase
    end
  endfunction

  // Effective configurations after following and preset.
  reg [`CFG_W-1:0] tx_eff;
  reg [`CFG_W-1:0] rx_eff;
  always @* begin
    tx_eff = (tx_follow && !port_is_first) ? p1_tx_cfg : tx_cfg;
    if (rx_follow == `FOLLOW_TX) begin
      rx_eff = tx_eff;
    end else if (rx_follow == `FOLLOW_P1RX && !port_is_first) begin
      rx_eff = p1_rx_cfg;
    end else begin
      rx_eff = rx_cfg;
    end
    if (std_preset) begin
      tx_eff[`CFG_PAT_HI:`CFG_PAT_LO] = `PAT_PRBS;
      tx_eff[`CFG_ORD_HI:`CFG_ORD_LO] = `STD_ORDER;
      tx_eff[`CFG_INV] = 1'b1;
      rx_eff[`CFG_PAT_HI:`CFG_PAT_LO] = `PAT_PRBS;
      rx_eff[`CFG_ORD_HI:`CFG_ORD_LO] = `STD_ORDER;
      rx_eff[`CFG_INV] = 1'b1;
    end
  end
  wire tx_on = tx_eff[`CFG_MODE];
  wire [3:0] tx_pat = tx_eff[`CFG_PAT_HI:`CFG_PAT_LO];
  wire [31:0] tx_mask = prbs_mask(tx_eff[`CFG_ORD_HI:`CFG_ORD_LO]);
  wire rx_on = rx_eff[`CFG_MODE];
  wire rx_frm = rx_eff[`CFG_FRAME];
  wire [3:0] rx_pat = rx_eff[`CFG_PAT_HI:`CFG_PAT_LO];
  wire [31:0] rx_mask = prbs_mask(rx_eff[`CFG_ORD_HI:`CFG_ORD_LO]);

  // User pattern store, shared by generator and checker.
  reg [2047:0] user_mem_reg;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      user_mem_reg <= 2048'h0;
    end else if (user_wr_en) begin
      user_mem_reg[user_wr_addr] <= user_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage and later are looked at.
  reg [1:0] ext_s1_reg;
  reg [2:0] ext_s2_reg;
  reg [2:0] rxin_s1_reg;
  reg [2:0] rxin_s2_reg;
  reg rxclk_d_reg;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1_reg <= 2'h0;
      ext_s2_reg <= 3'h0;
      rxin_s1_reg <= 3'h0;
      rxin_s2_reg <= 3'h0;
      rxclk_d_reg <= 1'b0;
    end else begin
      ext_s1_reg <= {ext_s1_reg[0], ext_clk};
      ext_s2_reg <= {ext_s2_reg[1:0], ext_s1_reg[1]};
      rxin_s1_reg <= {rx_clk, rx_pos, rx_neg};
      rxin_s2_reg <= rxin_s1_reg;
      rxclk_d_reg <= rxin_s2_reg[2];
    end
  end
  wire ext_rise = ext_s2_reg[1] && !ext_s2_reg[2];
  wire rx_rise = rxin_s2_reg[2] && !rxclk_d_reg;

  reg [17:0] acc_reg;
  reg [8:0] ext_gap_reg;
  reg [8:0] rx_gap_reg;
  // Sum kept wide: the accumulator plus one step can pass the 18-bit range.
  wire [31:0] acc_sum = acc_reg + `LINE_KBPS;
  wire [31:0] acc_wrap = acc_sum - `CORE_KHZ;
  wire int_tick = (acc_sum >= `CORE_KHZ);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= 18'h0;
      ext_gap_reg <= 9'h1ff;
      rx_gap_reg <= 9'h1ff;
    end else begin
      // Fractional divider averages the nominal line rate exactly.
      acc_reg <= int_tick ? acc_wrap[17:0] : acc_sum[17:0];
      ext_gap_reg <= ext_rise ? 9'h0 : (ext_gap_reg == 9'h1ff) ? ext_gap_reg : ext_gap_reg + 1'b1;
      rx_gap_reg <= rx_rise ? 9'h0 : (rx_gap_reg == 9'h1ff) ? rx_gap_reg : rx_gap_reg + 1'b1;
    end
  end
  wire ext_det = (ext_gap_reg < `CLKDET_CYC);
  wire rx_det = (rx_gap_reg < `CLKDET_CYC);
  assign tx_clk_detected = (tx_clk_src == `SRC_EXT) ? ext_det :
                           (tx_clk_src == `SRC_REC) ? rx_det : 1'b1;
  wire tx_bit_en = tx_on && ((tx_clk_src == `SRC_EXT) ? ext_rise :
                             (tx_clk_src == `SRC_REC) ? rx_rise : int_tick);

  ////////////////////////////////////////////////////////////////////////////////
  // Pattern generator fills the FIFO whenever it has room.
  reg [31:0] g_lfsr_reg;
  reg [11:0] g_idx_reg;
  wire g_ready;
  wire g_fb = ^(g_lfsr_reg & tx_mask);
  wire g_raw = (tx_pat == `PAT_PRBS) ? g_fb : word_bit(tx_pat, g_idx_reg, user_mem_reg[g_idx_reg[10:0]]);
  // Inversion applies to every generated bit except with the pattern off, which sends zeros.
  wire g_bit = (tx_pat == `PAT_OFF) ? 1'b0 : g_raw ^ tx_eff[`CFG_INV];
  wire [11:0] g_len = pat_len(tx_pat, user_len);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      g_lfsr_reg <= 32'h1;
      g_idx_reg <= 12'h0;
    end else if (!tx_on) begin
      g_lfsr_reg <= 32'h1;
      g_idx_reg <= 12'h0;
    end else if (g_ready) begin
      g_lfsr_reg <= (g_lfsr_reg == 32'h0) ? 32'h1 : {g_lfsr_reg[30:0], g_fb};
      g_idx_reg <= (g_idx_reg + 1'b1 >= g_len) ? 12'h0 : g_idx_reg + 1'b1;
    end
  end

  // Framer position and payload slot selection.
  reg [10:0] t_pos_reg;
  reg [3:0] t_par_reg;
  reg [3:0] t_par_last_reg;
  wire t_frm = tx_eff[`CFG_FRAME];
  wire t_par_en = t_frm && tx_eff[`CFG_PAR];
  wire t_ovh = t_frm && (t_pos_reg < `OVH_BITS);
  wire t_par_slot = t_par_en && (t_pos_reg >= `PAR_START);
  wire t_payload = !t_ovh && !t_par_slot;
  wire f_valid;
  wire f_data;
  wire [9:0] faw = `FAW_WORD;
  reg t_bit;
  always @* begin
    // Overhead only when frame insertion is on
    if (t_ovh) begin
      t_bit = (t_pos_reg <= `FAW_END) ? faw[4'd9 - t_pos_reg[3:0]] : t_pos_reg[0];
    end else if (t_par_slot) begin
      t_bit = t_par_last_reg[t_pos_reg[1:0]];
    end else begin
      t_bit = f_valid ? f_data : 1'b0;
    end
  end
  e3_bit_fifo #(.WIDTH(1), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(tx_on),
    .in_ready(g_ready),
    .in_data(g_bit),
    .out_valid(f_valid),
    .out_ready(tx_bit_en && t_payload),
    .out_data(f_data)
  );
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      t_pos_reg <= 11'h0;
      t_par_reg <= 4'h0;
      t_par_last_reg <= 4'h0;
    end else if (tx_bit_en) begin
      t_pos_reg <= (t_pos_reg == `FRAME_LAST) ? 11'h0 : t_pos_reg + 1'b1;
      if (t_pos_reg == `FRAME_LAST) begin
        t_par_last_reg <= t_par_reg;
        t_par_reg <= 4'h0;
      end else if (t_payload) begin
        t_par_reg[t_pos_reg[1:0]] <= t_par_reg[t_pos_reg[1:0]] ^ t_bit;
      end
    end
  end

  localparam SYM_ZERO = 2'h0;
  localparam SYM_MARK = 2'h1;
  localparam SYM_B = 2'h2;
  localparam SYM_V = 2'h3;
  reg [7:0] sym_reg;
  reg pol_reg;
  reg odd_reg;
  reg [7:0] sym_next;
  // Parity must include the symbol leaving now; a violation leaving resets it.
  wire odd_now = (sym_reg[7:6] == SYM_V) ? 1'b0 : (odd_reg ^ (sym_reg[7:6] != SYM_ZERO));
  always @* begin
    sym_next = {sym_reg[5:0], t_bit ? SYM_MARK : SYM_ZERO};
    if (sym_next == 8'h00) begin
      sym_next[7:6] = odd_now ? SYM_ZERO : SYM_B;
      sym_next[1:0] = SYM_V;
    end
  end
  // Line is released while the transmitter is off.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sym_reg <= 8'h0;
      pol_reg <= 1'b0;
      odd_reg <= 1'b0;
      line_pos <= 1'b0;
      line_neg <= 1'b0;
      line_oe <= 1'b0;
    end else if (!tx_on) begin
      sym_reg <= 8'h0;
      line_pos <= 1'b0;
      line_neg <= 1'b0;
      line_oe <= 1'b0;
    end else begin
      line_oe <= 1'b1;
      if (tx_bit_en) begin
        sym_reg <= sym_next;
        case (sym_reg[7:6])
          SYM_MARK, SYM_B: begin
            pol_reg <= !pol_reg;
            odd_reg <= !odd_reg;
            line_pos <= !pol_reg;
            line_neg <= pol_reg;
          end
          SYM_V: begin
            odd_reg <= 1'b0;
            line_pos <= pol_reg;
            line_neg <= !pol_reg;
          end
          default: begin
            line_pos <= 1'b0;
            line_neg <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive HDB3 decoder: a violation zeroes the last four bits.
  reg [3:0] hist_reg;
  reg last_pol_reg;
  reg [5:0] zrun_reg;
  wire r_p = rxin_s2_reg[1];
  wire r_n = rxin_s2_reg[0];
  wire r_mark = r_p ^ r_n;
  wire r_viol = r_mark && (r_p == last_pol_reg);
  wire r_bit = hist_reg[3];
  wire r_en = rx_on && rx_rise;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hist_reg <= 4'h0;
      last_pol_reg <= 1'b0;
      zrun_reg <= 6'h0;
      code_err_cnt <= 16'h0;
      alarm_los <= 1'b0;
    end else if (!rx_on) begin
      hist_reg <= 4'h0;
      zrun_reg <= 6'h0;
      alarm_los <= 1'b0;
    end else begin
      alarm_los <= (zrun_reg == `LOS_ZERO_RUN) || !rx_det;
      if (r_en) begin
        hist_reg <= r_viol ? 4'h0 : {hist_reg[2:0], r_mark};
        zrun_reg <= r_mark ? 6'h0 : (zrun_reg == `LOS_ZERO_RUN) ? zrun_reg : zrun_reg + 1'b1;
        if (r_mark) begin
          last_pol_reg <= r_p;
        end
        // Code errors: double pulse or bare violation
        if ((r_p && r_n) || (r_viol && hist_reg[1:0] != 2'h0)) begin
          code_err_cnt <= (code_err_cnt == 16'hffff) ? code_err_cnt : code_err_cnt + 1'b1;
        end
      end
    end
  end

  // Frame alignment: hunt, confirm, locked.
  localparam FA_HUNT = 2'h0;
  localparam FA_CONF = 2'h1;
  localparam FA_LOCK = 2'h2;
  reg [1:0] fa_state_reg;
  reg [1:0] fa_good_reg;
  reg [2:0] fa_bad_reg;
  reg [10:0] r_pos_reg;
  reg [9:0] r_sh_reg;
  reg [10:0] ais_pos_reg;
  reg [10:0] ais_zero_reg;
  wire [9:0] r_word = {r_sh_reg[8:0], r_bit};
  wire faw_ok = (r_word == `FAW_WORD);
  wire r_locked = (fa_state_reg == FA_LOCK);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fa_state_reg <= FA_HUNT;
      fa_good_reg <= 2'h0;
      fa_bad_reg <= 3'h0;
      r_pos_reg <= 11'h0;
      r_sh_reg <= 10'h0;
      ais_pos_reg <= 11'h0;
      ais_zero_reg <= 11'h0;
      faw_err_cnt <= 16'h0;
      alarm_ais <= 1'b0;
      alarm_no_frame <= 1'b0;
      alarm_distant <= 1'b0;
    end else if (!rx_on || !rx_frm) begin
      fa_state_reg <= FA_HUNT;
      r_pos_reg <= 11'h0;
      alarm_no_frame <= 1'b0;
      alarm_distant <= 1'b0;
      alarm_ais <= 1'b0;
    end else begin
      alarm_no_frame <= !r_locked;
      if (r_en) begin
        r_sh_reg <= r_word;
        r_pos_reg <= (r_pos_reg == `FRAME_LAST) ? 11'h0 : r_pos_reg + 1'b1;
        ais_pos_reg <= (ais_pos_reg == `FRAME_LAST) ? 11'h0 : ais_pos_reg + 1'b1;
        ais_zero_reg <= (ais_pos_reg == `FRAME_LAST) ? 11'h0 : ais_zero_reg + {10'h0, !r_bit};
        if (ais_pos_reg == `FRAME_LAST) begin
          alarm_ais <= (ais_zero_reg < `AIS_MAX_ZEROS);
        end
        if (r_pos_reg == `ALARM_POS && r_locked) begin
          alarm_distant <= r_bit;
        end
        case (fa_state_reg)
          FA_HUNT: begin
            if (faw_ok) begin
              fa_state_reg <= FA_CONF;
              fa_good_reg <= 2'h1;
              r_pos_reg <= `FAW_END + 1'b1;
            end
          end
          FA_CONF: begin
            if (r_pos_reg == `FAW_END) begin
              fa_good_reg <= fa_good_reg + 1'b1;
              fa_bad_reg <= 3'h0;
              fa_state_reg <= !faw_ok ? FA_HUNT :
                              (fa_good_reg + 1'b1 == `FA_GAIN) ? FA_LOCK : FA_CONF;
            end
          end
          FA_LOCK: begin
            if (r_pos_reg == `FAW_END) begin
              if (!faw_ok) begin
                faw_err_cnt <= (faw_err_cnt == 16'hffff) ? faw_err_cnt : faw_err_cnt + 1'b1;
                fa_bad_reg <= fa_bad_reg + 1'b1;
                if (fa_bad_reg + 1'b1 == `FA_LOSE) begin
                  fa_state_reg <= FA_HUNT;
                end
              end else begin
                fa_bad_reg <= 3'h0;
              end
            end
          end
          default: fa_state_reg <= FA_HUNT;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pattern checker, same pattern set
  wire r_payload = !rx_frm || (r_locked && r_pos_reg >= `OVH_BITS &&
                   !(rx_eff[`CFG_PAR] && r_pos_reg >= `PAR_START));
  reg [31:0] c_lfsr_reg;
  reg [11:0] c_idx_reg;
  reg c_sync_reg;
  reg c_was_sync_reg;
  reg [5:0] c_run_reg;
  reg [5:0] c_win_reg;
  reg [3:0] c_errs_reg;
  wire [11:0] c_len = pat_len(rx_pat, user_len);
  wire c_fb = ^(c_lfsr_reg & rx_mask);
  wire c_rx = r_bit ^ rx_eff[`CFG_INV];
  wire c_exp = (rx_pat == `PAT_PRBS) ? c_fb : word_bit(rx_pat, c_idx_reg, user_mem_reg[c_idx_reg[10:0]]);
  wire c_err = (c_rx != c_exp);
  wire [11:0] c_step = (c_err && !c_sync_reg) ? 12'h2 : 12'h1;
  wire [12:0] c_idx_sum = {1'b0, c_idx_reg} + {1'b0, c_step};
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      c_lfsr_reg <= 32'h1;
      c_idx_reg <= 12'h0;
      c_sync_reg <= 1'b0;
      c_was_sync_reg <= 1'b0;
      c_run_reg <= 6'h0;
      c_win_reg <= 6'h0;
      c_errs_reg <= 4'h0;
      pat_err_cnt <= 16'h0;
      slip_cnt <= 16'h0;
      alarm_no_sync <= 1'b0;
    end else if (!rx_on || rx_pat == `PAT_OFF) begin
      c_sync_reg <= 1'b0;
      c_was_sync_reg <= 1'b0;
      c_run_reg <= 6'h0;
      alarm_no_sync <= 1'b0;
    end else begin
      alarm_no_sync <= !c_sync_reg;
      if (r_en && r_payload) begin
        // Unsynced PRBS reseeds from the line; unsynced words slip one bit on error.
        c_lfsr_reg <= {c_lfsr_reg[30:0], c_sync_reg ? c_fb : c_rx};
        c_idx_reg <= (c_idx_sum >= {1'b0, c_len}) ? c_idx_sum[11:0] - c_len : c_idx_sum[11:0];
        if (!c_sync_reg) begin
          c_run_reg <= c_err ? 6'h0 : c_run_reg + 1'b1;
          if (!c_err && c_run_reg + 1'b1 == `SYNC_GOOD) begin
            c_sync_reg <= 1'b1;
            c_win_reg <= 6'h0;
            c_errs_reg <= 4'h0;
            // Regaining sync after a loss is a slip
            if (c_was_sync_reg) begin
              slip_cnt <= (slip_cnt == 16'hffff) ? slip_cnt : slip_cnt + 1'b1;
            end
          end
        end else begin
          c_win_reg <= c_win_reg + 1'b1;
          if (c_err) begin
            pat_err_cnt <= (pat_err_cnt == 16'hffff) ? pat_err_cnt : pat_err_cnt + 1'b1;
          end
          if (c_errs_reg + {3'h0, c_err} == `LOSS_ERRS) begin
            c_sync_reg <= 1'b0;
            c_was_sync_reg <= 1'b1;
            c_run_reg <= 6'h0;
          end else if (c_win_reg == 6'h3f) begin
            c_errs_reg <= 4'h0;
          end else begin
            c_errs_reg <= c_errs_reg + {3'h0, c_err};
          end
        end
      end
    end
  end
endmodule // e3_test_port

// *** rtl/e3_defines.vh ***
// Constants shared by the E3 test port framer and pattern logic.
`ifndef E3_DEFINES_VH
`define E3_DEFINES_VH
// Frame geometry.
`define FRAME_BITS 11'd1536
`define FRAME_LAST 11'd1535
`define FRAME_RATE_HZ 22375
`define FAW_WORD 10'h3d0
`define FAW_END 11'd9
`define ALARM_POS 11'd10
`define OVH_BITS 11'd12
`define PAR_BITS 11'd4
`define PAR_START 11'd1532
// Rates and timing.
`define CORE_KHZ 250000
`define LINE_KBPS 34368
`define TOL_PPM 125
`define CLKDET_NS 1000
`define CLKDET_CYC (`CLKDET_NS * `CORE_KHZ / 1000000)
// Configuration word fields.
`define CFG_W 13
`define CFG_MODE 0
`define CFG_FRAME 1
`define CFG_PAR 2
`define CFG_PAT_HI 6
`define CFG_PAT_LO 3
`define CFG_ORD_HI 11
`define CFG_ORD_LO 7
`define CFG_INV 12
// Pattern types.
`define PAT_OFF 4'h0
`define PAT_PRBS 4'h1
`define PAT_ZEROS 4'h2
`define PAT_ONES 4'h3
`define PAT_ALT11 4'h4
`define PAT_ALT13 4'h5
`define PAT_ALT17 4'h6
`define PAT_ALT324 4'h7
`define PAT_USER_SHORT 4'h8
`define PAT_USER_LONG 4'h9
`define STD_ORDER 5'h17
// Clock sources and following choices.
`define SRC_INT 2'h0
`define SRC_EXT 2'h1
`define SRC_REC 2'h2
`define FOLLOW_TX 2'h1
`define FOLLOW_P1RX 2'h2
// Alarm and sync thresholds, FIFO depth.
`define LOS_ZERO_RUN 6'h20
`define AIS_MAX_ZEROS 11'd3
`define FA_GAIN 2'h3
`define FA_LOSE 3'h4
`define SYNC_GOOD 6'h20
`define LOSS_ERRS 4'h8
`define FIFO_DEPTH 16
`endif

// *** verification/e3_port_monitor.sv ***
// Checker watching the E3 test port pins.
`timescale 1ns/1ns
module e3_port_monitor (
  input wire core_clk,
  input wire arst_n,
  input wire [12:0] tx_cfg,
  input wire [12:0] p1_tx_cfg,
  input wire [12:0] rx_cfg,
  input wire port_is_first,
  input wire tx_follow,
  input wire [1:0] rx_follow,
  input wire [1:0] tx_clk_src,
  input wire line_pos,
  input wire line_neg,
  input wire line_oe,
  input wire tx_clk_detected,
  input wire alarm_los,
  input wire alarm_no_frame,
  input wire [15:0] pat_err_cnt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Own settings count unless a permitted follow choice overrides them.
  wire tx_own = port_is_first | ~tx_follow;
  wire rx_off = ~rx_cfg[0] & ~^rx_follow;
  a_tx_off_idle: assert property (!tx_cfg[0] && tx_own |=> !line_oe && !line_pos)
    else $error("line driven with transmitter off");
  a_tx_on_drive: assert property (tx_cfg[0] && tx_own |=> line_oe)
    else $error("line not driven with transmitter on");
  a_follow_copy: assert property (!port_is_first && tx_follow && p1_tx_cfg[0] |=> line_oe)
    else $error("follower ignores first port");
  a_marks_single: assert property (!(line_pos && line_neg))
    else $error("both line polarities at once");
  a_int_clk_lamp: assert property (tx_clk_src == 2'h0 |-> tx_clk_detected)
    else $error("internal clock not detected");
  a_rx_off_quiet: assert property (rx_off |=> !alarm_los && !alarm_no_frame)
    else $error("alarm with receiver off");
  a_pat_cnt_hold: assert property (rx_off [*3] |=> $stable(pat_err_cnt))
    else $error("pattern errors counted with receiver off");
  a_nofr_unframed: assert property (!rx_cfg[1] && ~^rx_follow |=> !alarm_no_frame)
    else $error("frame alarm with framing off");
endmodule // e3_port_monitor
bind e3_test_port e3_port_monitor i_mon (.core_clk, .arst_n, .tx_cfg, .p1_tx_cfg, .rx_cfg,
  .port_is_first, .tx_follow, .rx_follow, .tx_clk_src, .line_pos, .line_neg, .line_oe,
  .tx_clk_detected, .alarm_los, .alarm_no_frame, .pat_err_cnt);

// *** verification/e3_line_partner.sv ***
// Far end model sending an all-ones HDB3 stream towards the receiver.
`timescale 1ns/1ns
module e3_line_partner (
  input wire en,
  input wire bad,
  output reg rx_clk,
  output reg rx_pos,
  output reg rx_neg
);
  reg mark_neg = 1'b0;
  // The line rests at zero from the start rather than showing unknowns.
  initial begin
    rx_clk = 1'b0;
    rx_pos = 1'b0;
    rx_neg = 1'b0;
  end
  // Bench bit period
  // The clock stands still while idle, so a dead line is really dead.
  always #80 rx_clk = en ? ~rx_clk : 1'b0;
  // Alternating mark polarity
  // A bad request repeats a polarity to make a code violation; a disabled line drops to
  // zero at once, even when its clock has already stopped low.
  always @(negedge rx_clk or negedge en) begin
    mark_neg = bad ? mark_neg : ~mark_neg;
    rx_pos = en & ~mark_neg;
    rx_neg = en & mark_neg;
  end
endmodule // e3_line_partner

// *** verification/tb_e3_test_port.sv ***
// Self-checking bench for the E3 test port.
`timescale 1ns/1ns
module tb_e3_test_port;
  reg core_clk = 1'b0, arst_n = 1'b0, port_is_first = 1'b1, tx_follow = 1'b0;
  reg p_en = 1'b0, p_bad = 1'b0, std_preset = 1'b0, loop = 1'b0;
  reg [12:0] tx_cfg = 13'h0, p1_tx_cfg = 13'h0, rx_cfg = 13'h0, p1_rx_cfg = 13'h0;
  reg [1:0] rx_follow = 2'h0, tx_clk_src = 2'h0;
  reg [15:0] base;
  wire rx_clk, rx_pos, rx_neg, line_pos, line_neg, line_oe, tx_clk_detected, alarm_los;
  wire alarm_no_sync;
  wire [15:0] code_err_cnt, pat_err_cnt;
  integer fail_count = 0, checks = 0;
  always #2 core_clk = ~core_clk;
  e3_test_port i_dut (.core_clk, .arst_n, .tx_cfg, .p1_tx_cfg, .rx_cfg, .p1_rx_cfg,
    .port_is_first, .tx_follow, .rx_follow, .std_preset, .tx_clk_src, .ext_clk(rx_clk),
    .user_wr_en(1'b0), .user_wr_addr(11'h0), .user_wr_data(1'b0), .user_len(12'h1), .line_pos,
    .line_neg, .line_oe, .rx_clk, .rx_pos(loop ? line_pos : rx_pos),
    .rx_neg(loop ? line_neg : rx_neg), .tx_clk_detected, .alarm_los, .alarm_ais(),
    .alarm_no_frame(), .alarm_distant(), .alarm_no_sync, .faw_err_cnt(), .pat_err_cnt,
    .code_err_cnt, .slip_cnt());
  e3_line_partner i_far (.en(p_en), .bad(p_bad), .rx_clk, .rx_pos, .rx_neg);
  ////////////////////////////////////////////////////////////////////////////////
  // Inputs change one nanosecond after the rising edge.
  task cyc(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Transmitter on, following the first port's settings, then off.
  task t_tx;
    begin
      tx_cfg = 13'h3;
      cyc(2);
      chk("line_oe", line_oe, 1);
      tx_cfg = 13'h0;
      port_is_first = 1'b0;
      tx_follow = 1'b1;
      p1_tx_cfg = 13'h3;
      cyc(2);
      chk("follow_oe", line_oe, 1);
      port_is_first = 1'b1;
      cyc(2);
      chk("first_oe", line_oe, 0);
      chk("line_idle", {line_pos, line_neg}, 0);
      $display("test tx done");
    end
  endtask
  // Receiver alarms, following, code errors and the clock lamp.
  task t_rx;
    begin
      port_is_first = 1'b0;
      rx_follow = 2'h2;
      p1_rx_cfg = 13'h1;
      cyc(300);
      chk("follow_los", alarm_los, 1);
      rx_follow = 2'h0;
      cyc(2);
      chk("off_los", alarm_los, 0);
      rx_cfg = 13'h1;
      tx_clk_src = 2'h1;
      cyc(300);
      chk("los", alarm_los, 1);
      chk("clk_lamp", tx_clk_detected, 0);
      p_en = 1'b1;
      cyc(4000);
      chk("los_gone", alarm_los, 0);
      chk("clk_lamp", tx_clk_detected, 1);
      base = code_err_cnt;
      cyc(400);
      chk("code_clean", code_err_cnt, base);
      p_bad = 1'b1;
      cyc(400);
      // Only the first repeat follows marks; later ones follow a history already zeroed.
      chk("code_count", code_err_cnt, base + 16'h1);
      $display("test rx done");
    end
  endtask
  // Line looped into the receiver, standard preset, unframed, clocked from the line.
  task t_loop;
    begin
      tx_follow = 1'b0;
      tx_cfg = 13'h1;
      rx_follow = 2'h1;
      tx_clk_src = 2'h2;
      std_preset = 1'b1;
      loop = 1'b1;
      cyc(6000);
      chk("no_sync", alarm_no_sync, 0);
      base = pat_err_cnt;
      cyc(2000);
      chk("pat_err", pat_err_cnt, base);
      $display("test loop done");
    end
  endtask
  initial begin
    cyc(4);
    arst_n = 1'b1;
    cyc(2);
    t_tx;
    t_rx;
    t_loop;
    give_verdict;
  end
  // Watchdog well beyond the expected run of about 13400 cycles.
  initial begin
    #100000;
    fail_count = fail_count + 1;
    give_verdict;
  end
endmodule // tb_e3_test_port
